// ==== rtl/gpm_pkg.sv ====
/*
 * Constants, register map and state encodings of the operating-mode sequencer.
 * Assumes a 100 MHz hclk and the AHB-Lite slave inside gpm_sequencer.
 */
package gpm_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int SETTLE_S = 180;
	localparam int SETTLE_MS = SETTLE_S * 1000;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_RUN = 8'h04;
	localparam logic [7:0] OFS_SLEEP = 8'h08;
	localparam logic [7:0] OFS_RUN2 = 8'h0c;
	localparam logic [7:0] OFS_SLEEP2 = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_CHAR = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	// ==========================================================
	// field layout
	localparam int CFG_BAUD_LSB = 0;
	localparam int BAUD_W = 17;
	localparam int CFG_RATE_LSB = 20;
	localparam int RATE_W = 4;
	localparam int CFG_AUG_BIT = 24;
	localparam int CFG_AIC_BIT = 25;
	localparam int CFG_LOG_BIT = 26;
	localparam int CFG_ORB_BIT = 27;
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_TYPE_LSB = 4;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_ACC_BIT = 9;
	localparam int ST_REJ_BIT = 10;
	localparam int ST_SECOND_BIT = 11;
	localparam int ST_PSW_BIT = 12;
	localparam int ST_HOT_BIT = 13;

	// ==========================================================
	// values after reset and limits
	localparam logic [16:0] BAUD_DEF = 17'h02580;
	localparam logic [16:0] BAUD_MIN = 17'h012c0;
	localparam logic [16:0] BAUD_MAX = 17'h1c200;
	localparam logic [3:0] RATE_DEF = 4'h1;
	localparam logic [3:0] RATE_MAX = 4'ha;
	localparam logic AUG_DEF = 1'b1;
	localparam logic AIC_DEF = 1'b1;
	localparam logic LOG_DEF = 1'b0;
	localparam logic ORB_DEF = 1'b0;

	// ==========================================================
	// commands
	localparam logic [1:0] KIND_STANDBY = 2'h1;
	localparam logic [1:0] KIND_PERIODIC = 2'h2;
	localparam logic [1:0] KIND_FITNESS = 2'h3;
	localparam logic [3:0] STBY_PARAM = 4'h0;
	localparam logic [3:0] TYPE_EXIT = 4'h0;
	localparam logic [3:0] TYPE_PER_BACKUP = 4'h1;
	localparam logic [3:0] TYPE_PER_STANDBY = 4'h2;
	localparam logic [3:0] TYPE_BACKUP = 4'h4;
	localparam logic [3:0] TYPE_LOCATE_STBY = 4'h8;
	localparam logic [3:0] TYPE_LOCATE_BKP = 4'h9;
	localparam logic [7:0] CH_START = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2a;

	// ==========================================================
	// synchroniser lanes
	localparam int SY_MAIN = 0;
	localparam int SY_BKP = 1;
	localparam int SY_HOST = 2;
	localparam int SY_RX = 3;
	localparam int SY_ACQ = 4;
	localparam int SY_FIX = 5;
	localparam int SYNC_W = 6;

	typedef enum logic [8:0] {
		M_OFF = 9'h001,
		M_ACQ = 9'h002,
		M_TRACK = 9'h004,
		M_STANDBY = 9'h008,
		M_BACKUP = 9'h010,
		M_PER_HOLD = 9'h020,
		M_PER_RUN = 9'h040,
		M_PER_SLEEP = 9'h080,
		M_LOWPWR = 9'h100
	} gpm_mode_type;

	typedef enum logic [3:0] {
		C_IDLE = 4'h1,
		C_BODY = 4'h2,
		C_HEX1 = 4'h4,
		C_HEX2 = 4'h8
	} gpm_ck_state_type;

endpackage

// ==== rtl/gpm_ck_if.sv ====
/*
 * Character stream to the checksum checker and its verdict pulses.
 * Assumes both ends run on hclk.
 */
interface gpm_ck_if;
	logic valid;
	logic [7:0] data;
	logic ok;
	logic bad;
	modport feed (output valid, output data, input ok, input bad);
	modport check (input valid, input data, output ok, output bad);
endinterface

// ==== rtl/gpm_cksum.sv ====
/*
 * Sentence checksum checker: xor of characters between start and star,
 * compared with the two hex digits that follow.
 * Assumes one character per valid pulse on hclk.
 */
module gpm_cksum (
	input logic hclk,
	input logic hresetn,
	gpm_ck_if.check ck
);
	import gpm_pkg::*;

	typedef struct packed {
		gpm_ck_state_type st;
		logic [7:0] x;
		logic [3:0] hi;
		logic ok;
		logic bad;
	} gpm_ck_reg_type;

	localparam gpm_ck_reg_type CK_RST = '{st: C_IDLE, x: 8'h00, hi: 4'h0, ok: 1'b0, bad: 1'b0};

	gpm_ck_reg_type r, n;
	logic [4:0] hv;

	// returns {digit valid, value}
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			return {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			return {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return 5'h00;
	endfunction

	assign hv = hex_val(ck.data);

	always_comb begin
		n = r;
		n.ok = 1'b0;
		n.bad = 1'b0;
		if (ck.valid) begin
			if (ck.data == CH_START) begin
				n.st = C_BODY;
				n.x = 8'h00;
			end else begin
				unique case (r.st)
					C_IDLE: begin
					end
					C_BODY: begin
						if (ck.data == CH_STAR) begin
							n.st = C_HEX1;
						end else begin
							n.x = r.x ^ ck.data;
						end
					end
					C_HEX1: begin
						n.hi = hv[3:0];
						n.st = hv[4] ? C_HEX2 : C_IDLE;
						n.bad = !hv[4];
					end
					C_HEX2: begin
						n.st = C_IDLE;
						n.ok = hv[4] && ({r.hi, hv[3:0]} == r.x); // RULE23
						n.bad = !n.ok;
					end
					default: begin
						n.st = C_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= CK_RST;
		end else begin
			r <= n;
		end
	end

	assign ck.ok = r.ok;
	assign ck.bad = r.bad;

	// ==========================================================
	// checks
	property p_ck_match;
		@(posedge hclk) disable iff (!hresetn)
		ck.valid && r.st == C_HEX2 && hv[4] && {r.hi, hv[3:0]} == r.x
		|=> ck.ok && !ck.bad;
	endproperty
	a_ck_match: assert property (p_ck_match) else $error("matching checksum not accepted"); // RULE23

endmodule

// ==== rtl/gpm_sequencer.sv ====
/*
 * Operating-mode sequencer of a positioning receiver with an AHB-Lite
 * register port; the checksum checker sits below it.
 * Assumes the supply, rx and engine status pins are asynchronous.
 */
// How it works
// RULE1: both supplies valid brings the receiver into full-on by itself, with defaults.
// RULE2: full-on starts in acquisition and moves to tracking by itself.
// RULE3: baud 4800 to 115200 and update 1 to 10 Hz are accepted.
// RULE4: orbit prediction is forced off when update rate exceeds 1 Hz.
// RULE5: standby keeps core, cuts radio and oscillator, no search, no sentences.
// RULE6: standby command with parameter zero from full-on enters standby.
// RULE7: any serial receive activity wakes standby back to full-on.
// RULE8: leaving standby or backup reuses aiding data for a hot start.
// RULE9: backup keeps only the backup supply; main is cut by host or switch.
// RULE10: power switch output is open drain, wired with host enable.
// RULE11: periodic type 4 with host enable low pulls the switch low.
// RULE12: the host wakes permanent backup only by raising its enable.
// RULE13: backup stops search and serial answers, keeps retained memory.
// RULE14: periodic command carries type and four millisecond periods.
// RULE15: no fix in run period selects second periods until fix returns.
// RULE16: after the periodic command full-on holds a settle time first.
// RULE17: periodic type 0 leaves periodic standby any time.
// RULE18: periodic type 0 leaves periodic backup only during run periods.
// RULE19: host holds enable low and keeps backup supply before periodic backup.
// RULE20: host starts periodic mode while tracking, longer second run if weak.
// RULE21: only full-on changes mode by command; others return to full-on.
// RULE22: the power switch state lives in the backup-powered domain.
// RULE23: commands act only when the sentence checksum matches.
module gpm_sequencer #(
	parameter int CYC_PER_MS_P = gpm_pkg::CYC_PER_MS,
	parameter int SETTLE_MS_P = gpm_pkg::SETTLE_MS
) (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input logic main_supply_ok,
	input logic backup_supply_ok,
	input logic host_power_enable,
	input logic serial_rx,
	input logic acq_done,
	input logic fix_valid,
	output logic rf_power_en,
	output logic osc_power_en,
	output logic search_en,
	output logic sentence_en,
	output logic serial_resp_en,
	output logic hot_start,
	output logic orbit_prediction_en,
	output logic interference_cancel_en,
	output logic position_logger_en,
	output logic augmentation_en,
	output logic [gpm_pkg::BAUD_W-1:0] baud_rate,
	output logic [gpm_pkg::RATE_W-1:0] update_rate,
	output logic power_switch_o,
	output logic power_switch_oe
);
	import gpm_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic rx_q;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic [BAUD_W-1:0] baud;
		logic [RATE_W-1:0] rate;
		logic aug;
		logic interference_cancel;
		logic logger;
		logic orb;
		logic [31:0] run;
		logic [31:0] sleep;
		logic [31:0] run2;
		logic [31:0] sleep2;
		logic [1:0] kind;
		logic [3:0] ctype;
		gpm_mode_type mode;
		logic per_bkp;
		logic second;
		logic fix_seen;
		logic [31:0] pre;
		logic [31:0] ms;
		logic psw;
		logic hot;
		logic acc;
		logic rej;
		logic [7:0] ch;
		logic ch_v;
		logic full_on;
		logic resp;
	} gpm_seq_reg_type;

	localparam gpm_seq_reg_type SEQ_RST = '{mode: M_OFF, baud: BAUD_DEF, rate: RATE_DEF,
		aug: AUG_DEF, interference_cancel: AIC_DEF, logger: LOG_DEF, orb: ORB_DEF, rx_q: 1'b1,
		s1: SYNC_W'(1 << SY_RX), s2: SYNC_W'(1 << SY_RX), default: '0};

	gpm_seq_reg_type r, n;
	gpm_ck_if ck ();
	logic sup;
	logic rx_fall;
	logic tick;
	logic fo;
	logic take;

	gpm_cksum u_cksum (
		.hclk(hclk),
		.hresetn(hresetn),
		.ck(ck.check)
	);

	// ==========================================================
	// decoders
	function automatic logic is_full_on(input gpm_mode_type m);
		return m inside {M_ACQ, M_TRACK, M_PER_HOLD, M_PER_RUN, M_LOWPWR};
	endfunction

	function automatic logic serial_dead(input gpm_mode_type m, input logic bkp);
		return m == M_OFF || m == M_BACKUP || (m == M_PER_SLEEP && bkp);
	endfunction

	function automatic logic [BAUD_W-1:0] clamp_baud(input logic [BAUD_W-1:0] b);
		if (b < BAUD_MIN) begin
			return BAUD_MIN;
		end else if (b > BAUD_MAX) begin
			return BAUD_MAX;
		end
		return b;
	endfunction

	function automatic logic [RATE_W-1:0] clamp_rate(input logic [RATE_W-1:0] v);
		if (v < RATE_DEF) begin
			return RATE_DEF;
		end else if (v > RATE_MAX) begin
			return RATE_MAX;
		end
		return v;
	endfunction

	assign sup = r.s2[SY_MAIN] && r.s2[SY_BKP];
	assign rx_fall = r.rx_q && !r.s2[SY_RX];
	assign tick = r.pre == 32'(CYC_PER_MS_P - 1);
	assign fo = r.mode == M_ACQ || r.mode == M_TRACK;

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		take = 1'b0;
		n.s1 = {fix_valid, acq_done, serial_rx, host_power_enable, backup_supply_ok, main_supply_ok};
		n.s2 = r.s1;
		n.rx_q = r.s2[SY_RX];
		n.ch_v = 1'b0;
		n.wr_pend = 1'b0;
		n.pre = tick ? 32'h0 : r.pre + 32'h1;
		n.ms = tick ? r.ms + 32'h1 : r.ms;

		// bus address phase
		if (hsel && hready && htrans[1]) begin
			n.wr_pend = hwrite;
			n.wr_addr = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					OFS_CONFIG: n.rdata = {4'h0, r.orb, r.logger, r.interference_cancel, r.aug, r.rate, 3'h0, r.baud};
					OFS_RUN: n.rdata = r.run;
					OFS_SLEEP: n.rdata = r.sleep;
					OFS_RUN2: n.rdata = r.run2;
					OFS_SLEEP2: n.rdata = r.sleep2;
					OFS_CMD: n.rdata = {24'h0, r.ctype, 2'h0, r.kind};
					OFS_STATUS: n.rdata = {18'h0, r.hot, r.psw, r.second, r.rej, r.acc, r.mode};
					default: n.rdata = 32'h0;
				endcase
			end
		end

		// bus data phase
		if (r.wr_pend) begin
			case (r.wr_addr)
				OFS_CONFIG: begin
					n.baud = clamp_baud(hwdata[CFG_BAUD_LSB +: BAUD_W]); // RULE3
					n.rate = clamp_rate(hwdata[CFG_RATE_LSB +: RATE_W]); // RULE3
					n.aug = hwdata[CFG_AUG_BIT];
					n.interference_cancel = hwdata[CFG_AIC_BIT];
					n.logger = hwdata[CFG_LOG_BIT];
					n.orb = hwdata[CFG_ORB_BIT] && (n.rate == RATE_DEF); // RULE4
				end
				OFS_RUN: n.run = hwdata; // RULE14
				OFS_SLEEP: n.sleep = hwdata;
				OFS_RUN2: n.run2 = hwdata;
				OFS_SLEEP2: n.sleep2 = hwdata;
				OFS_CMD: begin
					n.kind = hwdata[CMD_KIND_LSB +: 2];
					n.ctype = hwdata[CMD_TYPE_LSB +: 4];
				end
				OFS_CHAR: begin
					// serial port is unpowered in backup
					n.ch_v = !serial_dead(r.mode, r.per_bkp); // RULE13
					n.ch = hwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// ==========================================================
		// mode machine
		unique case (r.mode)
			M_OFF: begin
				if (sup) begin
					n.mode = M_ACQ; // RULE1
				end
			end
			M_ACQ: begin
				if (r.s2[SY_ACQ]) begin
					n.mode = M_TRACK; // RULE2
					n.hot = 1'b0;
				end
			end
			M_TRACK: begin
			end
			M_STANDBY: begin
				if (rx_fall || r.ch_v) begin
					n.mode = M_ACQ; // RULE7
					n.hot = 1'b1; // RULE8
				end
			end
			M_BACKUP: begin
				if (r.s2[SY_HOST]) begin
					n.psw = 1'b0;
				end
				if (!r.psw && sup) begin
					n.mode = M_ACQ;
					n.hot = 1'b1; // RULE8
				end
			end
			M_PER_HOLD: begin
				if (r.ms >= 32'(SETTLE_MS_P)) begin
					n.mode = M_PER_RUN; // RULE16
					n.ms = 32'h0;
					n.pre = 32'h0;
					n.fix_seen = 1'b0;
				end
			end
			M_PER_RUN: begin
				n.fix_seen = r.fix_seen || r.s2[SY_FIX];
				if (r.ms >= (r.second ? r.run2 : r.run)) begin
					n.mode = M_PER_SLEEP;
					n.second = !n.fix_seen; // RULE15
					n.psw = r.per_bkp; // RULE9
					n.ms = 32'h0;
					n.pre = 32'h0;
				end
			end
			M_PER_SLEEP: begin
				if (r.ms >= (r.second ? r.sleep2 : r.sleep)) begin
					n.psw = 1'b0;
					if (sup) begin
						n.mode = M_PER_RUN;
						n.hot = 1'b1;
						n.fix_seen = 1'b0;
						n.ms = 32'h0;
						n.pre = 32'h0;
					end
				end
			end
			M_LOWPWR: begin
			end
			default: begin
				n.mode = M_OFF;
			end
		endcase

		// ==========================================================
		// command execution
		if (ck.ok) begin
			unique case (r.kind)
				KIND_STANDBY: begin
					if (fo && r.ctype == STBY_PARAM) begin
						take = 1'b1;
						n.mode = M_STANDBY; // RULE6
					end
				end
				KIND_PERIODIC: begin
					case (r.ctype)
						TYPE_EXIT: begin
							if (r.mode inside {M_PER_HOLD, M_PER_RUN, M_LOWPWR} ||
								(r.mode == M_PER_SLEEP && !r.per_bkp)) begin
								take = 1'b1; // RULE17 RULE18
								n.mode = M_ACQ;
								n.hot = 1'b1;
								n.psw = 1'b0;
							end
						end
						TYPE_PER_BACKUP, TYPE_PER_STANDBY: begin
							if (fo) begin
								take = 1'b1;
								n.mode = M_PER_HOLD; // RULE16
								n.per_bkp = r.ctype == TYPE_PER_BACKUP; // RULE14
								n.second = 1'b0;
								n.ms = 32'h0;
								n.pre = 32'h0;
							end
						end
						TYPE_BACKUP: begin
							if (fo && !r.s2[SY_HOST]) begin
								take = 1'b1;
								n.mode = M_BACKUP; // RULE11
								n.psw = 1'b1; // RULE22
							end
						end
						TYPE_LOCATE_STBY, TYPE_LOCATE_BKP: begin
							if (fo) begin
								take = 1'b1;
								n.mode = M_LOWPWR;
							end
						end
						default: begin
						end
					endcase
				end
				KIND_FITNESS: begin
					if (fo) begin
						take = 1'b1;
						n.mode = M_LOWPWR; // RULE21
					end
				end
				default: begin
				end
			endcase
		end
		if (ck.ok || ck.bad) begin
			n.acc = take;
			n.rej = !take;
		end

		// main or backup supply lost outside backup
		if (!sup && !serial_dead(r.mode, r.per_bkp)) begin
			n.mode = M_OFF;
			n.hot = 1'b0;
		end

		n.full_on = is_full_on(n.mode); // RULE5
		n.resp = !serial_dead(n.mode, n.per_bkp); // RULE13
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= SEQ_RST;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs
	assign ck.valid = r.ch_v;
	assign ck.data = r.ch;
	assign hrdata = r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rf_power_en = r.full_on;
	assign osc_power_en = r.full_on;
	assign search_en = r.full_on;
	assign sentence_en = r.full_on;
	assign serial_resp_en = r.resp;
	assign hot_start = r.hot;
	assign orbit_prediction_en = r.orb;
	assign interference_cancel_en = r.interference_cancel;
	assign position_logger_en = r.logger;
	assign augmentation_en = r.aug;
	assign baud_rate = r.baud;
	assign update_rate = r.rate;
	assign power_switch_o = 1'b0; // RULE10
	assign power_switch_oe = r.psw;

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_boot;
		r.mode == M_OFF && sup && !ck.ok |=> r.mode == M_ACQ ##0 rf_power_en;
	endproperty
	a_boot: assert property (p_boot) else $error("no full-on after supplies valid"); // RULE1

	property p_acq;
		r.mode == M_ACQ && r.s2[SY_ACQ] && sup && !ck.ok |=> r.mode == M_TRACK;
	endproperty
	a_acq: assert property (p_acq) else $error("acquisition did not move to tracking"); // RULE2

	property p_range;
		update_rate >= RATE_DEF && update_rate <= RATE_MAX && baud_rate >= BAUD_MIN && baud_rate <= BAUD_MAX;
	endproperty
	a_range: assert property (p_range) else $error("rate or baud out of range"); // RULE3

	property p_orb;
		update_rate != RATE_DEF |-> !orbit_prediction_en;
	endproperty
	a_orb: assert property (p_orb) else $error("orbit prediction on above 1 Hz"); // RULE4

	property p_standby;
		r.mode == M_STANDBY |-> !rf_power_en && !osc_power_en && !sentence_en && serial_resp_en;
	endproperty
	a_standby: assert property (p_standby) else $error("standby outputs wrong"); // RULE5

	property p_wake;
		r.mode == M_STANDBY && rx_fall && sup |=> r.mode == M_ACQ && hot_start;
	endproperty
	a_wake: assert property (p_wake) else $error("standby did not wake on rx"); // RULE7

	property p_backup;
		r.mode == M_BACKUP && $past(r.mode) != M_BACKUP |-> power_switch_oe && !power_switch_o;
	endproperty
	a_backup: assert property (p_backup) else $error("switch not pulled on backup entry"); // RULE11

	property p_star;
		$changed(r.mode) && r.mode inside {M_STANDBY, M_BACKUP, M_PER_HOLD, M_LOWPWR}
		|-> $past(r.mode) inside {M_ACQ, M_TRACK};
	endproperty
	a_star: assert property (p_star) else $error("mode entered from outside full-on"); // RULE21

	property p_bkp_sleep;
		r.mode == M_PER_SLEEP && r.per_bkp |-> !serial_resp_en && !search_en;
	endproperty
	a_bkp_sleep: assert property (p_bkp_sleep) else $error("serial alive in backup sleep"); // RULE13

	c_standby_wake: cover property (r.mode == M_STANDBY ##1 r.mode == M_ACQ);
	c_per_sleep: cover property (r.mode == M_PER_RUN ##1 r.mode == M_PER_SLEEP);
	c_backup: cover property (r.mode == M_BACKUP && !power_switch_oe);

endmodule

// ==== verif/gpm_host_model.sv ====
/*
 * Far side of the sequencer: host enable wired with the open-drain switch,
 * serial frames on the receive line and a simple positioning engine.
 * Assumes hclk from the bench; wake is a one-cycle request.
 */
module gpm_host_model (
	input wire logic hclk,
	input wire logic main_src,
	input wire logic host_power_enable,
	input wire logic power_switch_o,
	input wire logic power_switch_oe,
	input wire logic search_en,
	input wire logic eng_acq,
	input wire logic fix_ok,
	input wire logic wake,
	output logic main_supply_ok,
	output logic serial_rx,
	output logic acq_done,
	output logic fix_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sw_line;
	logic ad = 1'b0;
	logic [9:0] fr = 10'h3ff;
	int n = 0;
	int dl = 0;
	// ==========
	// pull-up on the switch line, or-ed with the host enable
	assign sw_line = power_switch_oe ? power_switch_o : 1'b1;
	assign main_supply_ok = main_src & (host_power_enable | sw_line);
	assign serial_rx = fr[0];
	assign fix_valid = fix_ok & search_en;
	assign acq_done = ad;
	// ==========
	// one random byte, start bit first, four cycles a bit
	always @(posedge hclk) begin
		if (wake) begin
			fr <= {1'b1, 8'($urandom), 1'b0};
			n <= 40;
		end else if (n > 0) begin
			n <= n - 1;
			if (n % 4 == 1)
				fr <= {1'b1, fr[9:1]};
		end
	end
	// ==========
	// acquisition ends a random few cycles after search starts
	always @(posedge hclk) begin
		if (!(search_en && eng_acq)) begin
			ad <= 1'b0;
			dl <= 1 + int'($urandom % 8);
		end else if (dl > 0)
			dl <= dl - 1;
		else
			ad <= 1'b1;
	end
endmodule

// ==== verif/gpm_sequencer_tb.sv ====
/*
 * Self-checking bench of gpm_sequencer: bus master tasks, command sentences
 * and mode polling. Assumes gpm_host_model on the far side.
 */
module gpm_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpm_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, bkp = 1'b0, main_src = 1'b0, host_en = 1'b0;
	logic eng_acq = 1'b0, fix_ok = 1'b0, wake = 1'b0, main_ok, rx, acq, fix;
	logic rf, osc, srch, sent, sresp, hot, orb, interference_cancel, logg, aug, psw_o, psw_oe;
	logic [16:0] baud;
	logic [3:0] rate;
	logic [31:0] q[$], qs[$];
	int errors = 0, n_compared = 0, cyc = 0, obs_n = 0;
	always #5 hclk = ~hclk;
	gpm_sequencer #(.CYC_PER_MS_P(4), .SETTLE_MS_P(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .main_supply_ok(main_ok),
		.backup_supply_ok(bkp), .host_power_enable(host_en), .serial_rx(rx), .acq_done(acq),
		.fix_valid(fix), .rf_power_en(rf), .osc_power_en(osc), .search_en(srch), .sentence_en(sent),
		.serial_resp_en(sresp), .hot_start(hot), .orbit_prediction_en(orb), .interference_cancel_en(interference_cancel),
		.position_logger_en(logg), .augmentation_en(aug), .baud_rate(baud), .update_rate(rate),
		.power_switch_o(psw_o), .power_switch_oe(psw_oe));
	gpm_host_model u_host (.hclk(hclk), .main_src(main_src), .host_power_enable(host_en),
		.power_switch_o(psw_o), .power_switch_oe(psw_oe), .search_en(srch), .eng_acq(eng_acq),
		.fix_ok(fix_ok), .wake(wake), .main_supply_ok(main_ok), .serial_rx(rx), .acq_done(acq),
		.fix_valid(fix));
	// ==========
	// checking
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	always @(obs_n) while (qs.size() > 0) check(qs.pop_front(), q.pop_front());
	task automatic see(input logic [31:0] v, input logic [31:0] e);
		q.push_back(e);
		qs.push_back(v);
		obs_n++;
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// ==========
	// bus master
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		see(r & m, e);
		see({31'h0, hresp}, 32'h0);
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int i;
		i = 0;
		xfer(1'b0, a, 32'h0);
		while ((r & m) !== e && i < 200) begin
			xfer(1'b0, a, 32'h0);
			i++;
		end
		see(r & m, e);
	endtask
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction
	// sentence of three random letters; bad spoils the checksum
	task automatic cmd(input logic [1:0] k, input logic [3:0] t, input logic bad);
		logic [7:0] b[3];
		logic [7:0] x;
		x = 8'h0;
		xfer(1'b1, OFS_CMD, {24'h0, t, 2'h0, k});
		xfer(1'b1, OFS_CHAR, {24'h0, CH_START});
		foreach (b[i]) begin
			b[i] = 8'h41 + 8'($urandom % 26);
			x ^= b[i];
			xfer(1'b1, OFS_CHAR, {24'h0, b[i]});
		end
		x ^= {7'h0, bad};
		xfer(1'b1, OFS_CHAR, {24'h0, CH_STAR});
		xfer(1'b1, OFS_CHAR, {24'h0, hx(x[7:4])});
		xfer(1'b1, OFS_CHAR, {24'h0, hx(x[3:0])});
	endtask
	task automatic pulse_wake();
		wake <= 1'b1;
		@(posedge hclk);
		wake <= 1'b0;
	endtask
	// ==========
	// main sequence
	initial begin
		int cb[4], cr[4], be, re;
		logic [1:0] lk[3];
		logic [3:0] lt[3];
		logic oe;
		void'($urandom(76323));
		cb = '{int'($urandom_range(115200, 4800)), 100, 130000, 9600};
		cr = '{int'($urandom_range(10, 1)), 0, 15, 1};
		lk = '{KIND_PERIODIC, KIND_PERIODIC, KIND_FITNESS};
		lt = '{TYPE_LOCATE_STBY, TYPE_LOCATE_BKP, 4'h0};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_CONFIG, 32'hffffffff, 32'h03102580);
		rd(8'h40, 32'hffffffff, 32'h0);
		rd(OFS_STATUS, 32'h1ff, 32'h001);
		bkp <= 1'b1;
		main_src <= 1'b1;
		poll(OFS_STATUS, 32'h1ff, 32'h002);
		see({25'h0, rf, osc, srch, sent, interference_cancel, aug, logg}, 32'h7e);
		eng_acq <= 1'b1;
		poll(OFS_STATUS, 32'h1ff, 32'h004);
		foreach (cb[i]) begin
			be = cb[i] < 4800 ? 4800 : (cb[i] > 115200 ? 115200 : cb[i]);
			re = cr[i] < 1 ? 1 : (cr[i] > 10 ? 10 : cr[i]);
			oe = (re == 1);
			xfer(1'b1, OFS_CONFIG, {4'h0, 4'hb, 4'(cr[i]), 3'h0, 17'(cb[i])});
			rd(OFS_CONFIG, 32'h0fffffff, {4'h0, oe, 3'h3, 4'(re), 3'h0, 17'(be)});
			see({orb, 10'h0, rate, baud}, {oe, 10'h0, 4'(re), 17'(be)});
		end
		cmd(KIND_STANDBY, STBY_PARAM, 1'b1);
		poll(OFS_STATUS, 32'h7ff, 32'h404);
		cmd(KIND_STANDBY, STBY_PARAM, 1'b0);
		poll(OFS_STATUS, 32'h7ff, 32'h208);
		see({27'h0, rf, osc, srch, sent, sresp}, 32'h1);
		eng_acq <= 1'b0;
		pulse_wake();
		poll(OFS_STATUS, 32'h21ff, 32'h2002);
		eng_acq <= 1'b1;
		poll(OFS_STATUS, 32'h1ff, 32'h004);
		foreach (lk[i]) begin
			cmd(lk[i], lt[i], 1'b0);
			poll(OFS_STATUS, 32'h7ff, 32'h300);
			cmd(KIND_STANDBY, STBY_PARAM, 1'b0);
			poll(OFS_STATUS, 32'h7ff, 32'h500);
			eng_acq <= 1'b0;
			cmd(KIND_PERIODIC, TYPE_EXIT, 1'b0);
			poll(OFS_STATUS, 32'h7ff, 32'h202);
			eng_acq <= 1'b1;
			poll(OFS_STATUS, 32'h1ff, 32'h004);
		end
		xfer(1'b1, OFS_RUN, 32'h3);
		xfer(1'b1, OFS_SLEEP, 32'h2);
		xfer(1'b1, OFS_RUN2, 32'h4);
		xfer(1'b1, OFS_SLEEP2, 32'h2);
		cmd(KIND_PERIODIC, TYPE_PER_STANDBY, 1'b0);
		poll(OFS_STATUS, 32'h1ff, 32'h020);
		poll(OFS_STATUS, 32'h1ff, 32'h040);
		poll(OFS_STATUS, 32'h9ff, 32'h880);
		see({30'h0, rf, srch}, 32'h0);
		poll(OFS_STATUS, 32'h21ff, 32'h2040);
		fix_ok <= 1'b1;
		poll(OFS_STATUS, 32'h9ff, 32'h080);
		eng_acq <= 1'b0;
		cmd(KIND_PERIODIC, TYPE_EXIT, 1'b0);
		poll(OFS_STATUS, 32'h7ff, 32'h202);
		eng_acq <= 1'b1;
		poll(OFS_STATUS, 32'h1ff, 32'h004);
		xfer(1'b1, OFS_RUN, 32'h14);
		xfer(1'b1, OFS_SLEEP, 32'h3);
		cmd(KIND_PERIODIC, TYPE_PER_BACKUP, 1'b0);
		poll(OFS_STATUS, 32'h11ff, 32'h1080);
		see({27'h0, psw_o, psw_oe, main_ok, sresp, rf}, 32'h8);
		poll(OFS_STATUS, 32'h11ff, 32'h0040);
		eng_acq <= 1'b0;
		cmd(KIND_PERIODIC, TYPE_EXIT, 1'b0);
		poll(OFS_STATUS, 32'h7ff, 32'h202);
		eng_acq <= 1'b1;
		poll(OFS_STATUS, 32'h1ff, 32'h004);
		host_en <= 1'b1;
		cmd(KIND_PERIODIC, TYPE_BACKUP, 1'b0);
		poll(OFS_STATUS, 32'h7ff, 32'h404);
		host_en <= 1'b0;
		cmd(KIND_PERIODIC, TYPE_BACKUP, 1'b0);
		poll(OFS_STATUS, 32'h11ff, 32'h1010);
		eng_acq <= 1'b0;
		pulse_wake();
		repeat (50) @(posedge hclk);
		rd(OFS_STATUS, 32'h1ff, 32'h010);
		see({29'h0, psw_oe, main_ok, sresp}, 32'h4);
		host_en <= 1'b1;
		poll(OFS_STATUS, 32'h31ff, 32'h2002);
		see({31'h0, hot}, 32'h1);
		@(posedge hclk);
		end_of_test();
	end
endmodule
